/* File: core/dpsw_pkg.sv */
// constants, entry layout and state type for the default power sequence writer
// assumes a single 50 MHz control clock and a 16-bit codec register space
package dpsw_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ    = 50_000_000;
  localparam int unsigned CLK_PER_US     = CLK_FREQ_HZ / 1_000_000;
  // base unit of an entry delay, shifted left by the entry delay code
  localparam int unsigned DELAY_UNIT_NS  = 1000;
  localparam int unsigned DELAY_UNIT_CYC = (DELAY_UNIT_NS * CLK_PER_US + 999) / 1000;
  // longest run of the speaker sleep and speaker wake sequences
  localparam int unsigned SEQ_LIMIT_US   = 2000;
  localparam int unsigned SEQ_LIMIT_CYC  = SEQ_LIMIT_US * CLK_PER_US;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned IDX_W  = 7;
  localparam int unsigned DLY_W  = 24;
  localparam int unsigned RUN_W  = 20;
  localparam int unsigned QCNT_W = 12;

  // ---------------------------------------------------------------
  // register offsets and field positions
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_SEQ_CTRL  = 8'h5a;
  localparam logic [ADDR_W-1:0] REG_SEQ_STAT  = 8'hfc;
  localparam logic [ADDR_W-1:0] REG_SEQ_CFG   = 8'hfd;
  localparam logic [ADDR_W-1:0] REG_DAC_MUTE  = 8'h05;
  localparam logic [ADDR_W-1:0] REG_SPK_CTRL  = 8'h31;
  localparam logic [ADDR_W-1:0] REG_CP        = 8'h48;
  localparam logic [ADDR_W-1:0] REG_PWR       = 8'h19;
  localparam int unsigned       SEQ_GO_BIT    = 7;
  localparam int unsigned       CFG_AUTO_BIT  = 0;
  localparam int unsigned       DAC_MUTE_BIT  = 3;
  localparam int unsigned       SPK_DRIVE_LSB = 6;
  localparam int unsigned       CP_BIT        = 0;
  localparam int unsigned       VMID_LSB      = 7;

  // ---------------------------------------------------------------
  // launch codes, start indices and last indices
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] CODE_POWER_DOWN = 16'h009b;
  localparam logic [DATA_W-1:0] CODE_SPK_SLEEP  = 16'h00e4;
  localparam logic [DATA_W-1:0] CODE_SPK_WAKE   = 16'h00e8;
  localparam logic [IDX_W-1:0]  IDX_POWER_DOWN  = 7'h1b;
  localparam logic [IDX_W-1:0]  IDX_PD_LAST     = 7'h31;
  localparam logic [IDX_W-1:0]  IDX_SPK_SLEEP   = 7'h64;
  localparam logic [IDX_W-1:0]  IDX_SLEEP_LAST  = 7'h66;
  localparam logic [IDX_W-1:0]  IDX_SPK_WAKE    = 7'h68;

  // ---------------------------------------------------------------
  // reset values and quiescence threshold
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] REG_RESET     = 16'h0000;
  localparam logic              CFG_RESET     = 1'b0;
  localparam logic [QCNT_W-1:0] QUIET_SAMPLES = 12'h400;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] width;
    logic [3:0] start;
    logic [7:0] data;
    logic [3:0] delay;
    logic       end_of_sequence_flag;
  } dpsw_entry_t;

  typedef enum logic [1:0] {DPSW_IDLE, DPSW_EXEC, DPSW_WAIT} dpsw_state_t;

endpackage

/* File: core/dpsw_field_merge.sv */
// read-modify-write merge of one bit field into a register word
// assumes width of at most eight bits and start plus width within the word
module dpsw_field_merge (
  input  wire logic [dpsw_pkg::DATA_W-1:0] old_i,
  input  wire logic [7:0]                  data_i,
  input  wire logic [3:0]                  width_i,
  input  wire logic [3:0]                  start_i,
  output logic      [dpsw_pkg::DATA_W-1:0] merged_o,
  output logic      [dpsw_pkg::DATA_W-1:0] mask_o
);
  import dpsw_pkg::*;

  logic [DATA_W-1:0] ones;

  // ---------------------------------------------------------------
  // field mask and merge
  // ---------------------------------------------------------------
  always_comb begin
    ones     = 16'((17'h00001 << width_i) - 17'h00001);
    mask_o   = ones << start_i;
    merged_o = (old_i & ~mask_o) | ((16'(data_i) << start_i) & mask_o);
  end

endmodule // dpsw_field_merge

/* File: core/dpsw_top.sv */
// control write sequencer with default power down and speaker sleep/wake content
// assumes synchronous register port and dac sample strobe on sys_clk_i
// ---------------------------------------------------------------
// module
// ---------------------------------------------------------------
// Function
// - power-down code starts at entry 27
// - speaker-sleep code starts at entry 100
// - speaker-wake code starts at entry 104
// - headphone levels cleared, then level update
// - speaker levels cleared, then level update
// - entry 45 clears converters and amps
// - entry 47 clears bias, inputs, samplers
// - entry 48 clears startup bias, buffer
// - entry 49 clears midrail select, stops
// - sleep mutes path, then amps with update
// - sleep disables speaker outputs and ends
// - wake enables speaker outputs first
// - wake unmutes amps, then path, ends
// - sleep and wake finish within 2 ms
// - auto mode launches sleep on quiet playback
// - auto mode launches wake on nonzero sample after an auto sleep
module dpsw_top #(
  parameter int unsigned DELAY_UNIT_CYC = dpsw_pkg::DELAY_UNIT_CYC,
  parameter int unsigned SEQ_LIMIT_CYC  = dpsw_pkg::SEQ_LIMIT_CYC
) (
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_b_i,
  input  wire logic [dpsw_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [dpsw_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [dpsw_pkg::DATA_W-1:0] reg_rdata_o,
  input  wire logic [dpsw_pkg::DATA_W-1:0] dac_sample_i,
  input  wire logic                        dac_sample_vld_i,
  output logic                             seq_busy_o,
  output logic      [dpsw_pkg::IDX_W-1:0]  seq_index_o,
  output logic                             dac_mute_o,
  output logic      [1:0]                  speaker_drive_on_o,
  output logic                             charge_pump_on_o,
  output logic      [1:0]                  midrail_reference_select_o
);
  import dpsw_pkg::*;

  // ---------------------------------------------------------------
  // entry table
  // ---------------------------------------------------------------
  function automatic dpsw_entry_t mk(input logic [7:0] a, input logic [3:0] w,
                                     input logic [3:0] s, input logic [7:0] d,
                                     input logic [3:0] dl, input logic eo);
    mk = {a, w, s, d, dl, eo};
  endfunction

  // unlisted indices do a harmless dummy write and stop
  function automatic dpsw_entry_t rom_entry(input logic [IDX_W-1:0] idx);
    case (idx)
      7'h1b:   rom_entry = mk(8'h05, 4'h1, 4'h3, 8'h01, 4'h8, 1'b0);
      7'h1c:   rom_entry = mk(8'h00, 4'h1, 4'h7, 8'h01, 4'h0, 1'b0);
      7'h1d:   rom_entry = mk(8'h01, 4'h2, 4'h7, 8'h03, 4'h0, 1'b0);
      7'h1e:   rom_entry = mk(8'h45, 4'h5, 4'h3, 8'h0e, 4'h0, 1'b0);
      7'h1f:   rom_entry = mk(8'h60, 4'h5, 4'h3, 8'h0e, 4'h0, 1'b0);
      7'h20:   rom_entry = mk(8'h02, 4'h7, 4'h0, 8'h00, 4'h0, 1'b0);
      7'h21:   rom_entry = mk(8'h03, 4'h7, 4'h0, 8'h00, 4'h0, 1'b0);
      7'h22:   rom_entry = mk(8'h03, 4'h1, 4'h8, 8'h01, 4'h0, 1'b0);
      7'h23:   rom_entry = mk(8'h28, 4'h7, 4'h0, 8'h00, 4'h0, 1'b0);
      7'h24:   rom_entry = mk(8'h29, 4'h7, 4'h0, 8'h00, 4'h0, 1'b0);
      7'h25:   rom_entry = mk(8'h29, 4'h1, 4'h8, 8'h01, 4'h0, 1'b0);
      7'h26:   rom_entry = mk(8'h3c, 4'h5, 4'h3, 8'h00, 4'h0, 1'b0);
      7'h27:   rom_entry = mk(8'h3d, 4'h5, 4'h3, 8'h00, 4'h0, 1'b0);
      7'h28:   rom_entry = mk(8'h3e, 4'h5, 4'h3, 8'h00, 4'h0, 1'b0);
      7'h29:   rom_entry = mk(8'h45, 4'h8, 4'h0, 8'h00, 4'h0, 1'b0);
      7'h2a:   rom_entry = mk(8'h60, 4'h8, 4'h0, 8'h00, 4'h0, 1'b0);
      7'h2b:   rom_entry = mk(8'h31, 4'h2, 4'h6, 8'h00, 4'h0, 1'b0);
      7'h2c:   rom_entry = mk(8'h63, 4'h4, 4'h0, 8'h00, 4'h0, 1'b0);
      7'h2d:   rom_entry = mk(8'h1a, 4'h6, 4'h3, 8'h00, 4'h0, 1'b0);
      7'h2e:   rom_entry = mk(8'h48, 4'h1, 4'h0, 8'h00, 4'h0, 1'b0);
      7'h2f:   rom_entry = mk(8'h19, 4'h6, 4'h1, 8'h00, 4'h0, 1'b0);
      7'h30:   rom_entry = mk(8'h1c, 4'h2, 4'h3, 8'h00, 4'h0, 1'b0);
      7'h31:   rom_entry = mk(8'h19, 4'h2, 4'h7, 8'h00, 4'h0, 1'b1);
      7'h64:   rom_entry = mk(8'h31, 4'h1, 4'h4, 8'h01, 4'h0, 1'b0);
      7'h65:   rom_entry = mk(8'h31, 4'h3, 4'h0, 8'h07, 4'h0, 1'b0);
      7'h66:   rom_entry = mk(8'h31, 4'h2, 4'h6, 8'h00, 4'h0, 1'b1);
      7'h68:   rom_entry = mk(8'h31, 4'h2, 4'h6, 8'h03, 4'h0, 1'b0);
      7'h69:   rom_entry = mk(8'h31, 4'h3, 4'h0, 8'h04, 4'h0, 1'b0);
      7'h6a:   rom_entry = mk(8'h31, 4'h1, 4'h4, 8'h00, 4'h0, 1'b1);
      default: rom_entry = mk(8'hfe, 4'h1, 4'h0, 8'h00, 4'h0, 1'b1);
    endcase
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic        [DATA_W-1:0] regs_q [0:255];
  dpsw_state_t              state_q,      state_d;
  logic        [IDX_W-1:0]  idx_q,        idx_d;
  logic        [DLY_W-1:0]  dly_q,        dly_d;
  logic                     cfg_auto_q,   cfg_auto_d;
  logic        [DATA_W-1:0] rdata_q,      rdata_d;
  logic        [QCNT_W-1:0] zero_cnt_q,   zero_cnt_d;
  logic                     auto_muted_q, auto_muted_d;
  logic                     pend_sleep_q, pend_sleep_d;
  logic                     pend_wake_q,  pend_wake_d;
  dpsw_entry_t              entry;
  logic        [DATA_W-1:0] seq_old;
  logic        [DATA_W-1:0] seq_wdata;
  logic        [DATA_W-1:0] seq_mask;
  logic                     bus_launch;
  logic                     seq_we;
  logic                     take_sleep;
  logic                     take_wake;
  logic                     arr_we;
  logic        [ADDR_W-1:0] arr_waddr;
  logic        [DATA_W-1:0] arr_wdata;

  assign entry   = rom_entry(idx_q);
  assign seq_old = regs_q[entry.addr];

  dpsw_field_merge u_merge (
    .old_i    (seq_old),
    .data_i   (entry.data),
    .width_i  (entry.width),
    .start_i  (entry.start),
    .merged_o (seq_wdata),
    .mask_o   (seq_mask)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // a bus write holds the entry one cycle so the array keeps one write port
  assign bus_launch = reg_wr_i && (reg_addr_i == REG_SEQ_CTRL) && reg_wdata_i[SEQ_GO_BIT];
  assign seq_we     = (state_q == DPSW_EXEC) && !reg_wr_i;

  always_comb begin
    state_d    = state_q;
    idx_d      = idx_q;
    dly_d      = dly_q;
    take_sleep = 1'b0;
    take_wake  = 1'b0;
    unique case (state_q)
      DPSW_IDLE: begin
        if (bus_launch) begin
          idx_d   = reg_wdata_i[IDX_W-1:0];
          state_d = DPSW_EXEC;
        end else if (pend_sleep_q) begin
          idx_d      = IDX_SPK_SLEEP;
          state_d    = DPSW_EXEC;
          take_sleep = 1'b1;
        end else if (pend_wake_q) begin
          idx_d     = IDX_SPK_WAKE;
          state_d   = DPSW_EXEC;
          take_wake = 1'b1;
        end
      end
      DPSW_EXEC: begin
        if (seq_we) begin
          if (entry.delay != 4'h0) begin
            dly_d   = DLY_W'(DELAY_UNIT_CYC) << entry.delay;
            state_d = DPSW_WAIT;
          end else if (entry.end_of_sequence_flag) begin
            state_d = DPSW_IDLE;
          end else begin
            idx_d = idx_q + 7'h01;
          end
        end
      end
      DPSW_WAIT: begin
        if (dly_q <= 24'h000001) begin
          if (entry.end_of_sequence_flag) begin
            state_d = DPSW_IDLE;
          end else begin
            idx_d   = idx_q + 7'h01;
            state_d = DPSW_EXEC;
          end
        end else begin
          dly_d = dly_q - 24'h000001;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // automatic launch on quiet and resumed playback
  // ---------------------------------------------------------------
  always_comb begin
    zero_cnt_d   = zero_cnt_q;
    auto_muted_d = auto_muted_q;
    pend_sleep_d = pend_sleep_q && !take_sleep;
    pend_wake_d  = pend_wake_q && !take_wake;
    if (!cfg_auto_q) begin
      zero_cnt_d   = '0;
      auto_muted_d = 1'b0;
      pend_sleep_d = 1'b0;
      pend_wake_d  = 1'b0;
    end else if (dac_sample_vld_i) begin
      if (dac_sample_i == '0) begin
        if (zero_cnt_q != QUIET_SAMPLES) begin
          zero_cnt_d = zero_cnt_q + 12'h001;
        end
        if ((zero_cnt_q == QUIET_SAMPLES - 12'h001) && !auto_muted_q) begin
          pend_sleep_d = 1'b1;
          auto_muted_d = 1'b1;
        end
      end else begin
        zero_cnt_d = '0;
        if (auto_muted_q) begin
          auto_muted_d = 1'b0;
          // a sleep never started needs no wake
          if (pend_sleep_q && !take_sleep) begin
            pend_sleep_d = 1'b0;
          end else begin
            pend_wake_d = 1'b1;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  always_comb begin
    arr_we     = 1'b0;
    arr_waddr  = entry.addr;
    arr_wdata  = seq_wdata;
    cfg_auto_d = cfg_auto_q;
    rdata_d    = '0;
    if (reg_wr_i) begin
      if (reg_addr_i == REG_SEQ_CFG) begin
        cfg_auto_d = reg_wdata_i[CFG_AUTO_BIT];
      end else if (reg_addr_i != REG_SEQ_STAT) begin
        arr_we    = 1'b1;
        arr_waddr = reg_addr_i;
        arr_wdata = reg_wdata_i;
      end
    end else if (seq_we) begin
      arr_we = 1'b1;
    end
    if (reg_rd_i) begin
      if (reg_addr_i == REG_SEQ_STAT) begin
        rdata_d = {8'h00, (state_q != DPSW_IDLE), idx_q};
      end else if (reg_addr_i == REG_SEQ_CFG) begin
        rdata_d = {15'h0000, cfg_auto_q};
      end else begin
        rdata_d = regs_q[reg_addr_i];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < 256; i++) begin
        regs_q[i] <= REG_RESET;
      end
    end else if (arr_we) begin
      regs_q[arr_waddr] <= arr_wdata;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q      <= DPSW_IDLE;
      idx_q        <= '0;
      dly_q        <= '0;
      cfg_auto_q   <= CFG_RESET;
      rdata_q      <= '0;
      zero_cnt_q   <= '0;
      auto_muted_q <= 1'b0;
      pend_sleep_q <= 1'b0;
      pend_wake_q  <= 1'b0;
    end else begin
      state_q      <= state_d;
      idx_q        <= idx_d;
      dly_q        <= dly_d;
      cfg_auto_q   <= cfg_auto_d;
      rdata_q      <= rdata_d;
      zero_cnt_q   <= zero_cnt_d;
      auto_muted_q <= auto_muted_d;
      pend_sleep_q <= pend_sleep_d;
      pend_wake_q  <= pend_wake_d;
    end
  end

  assign reg_rdata_o                = rdata_q;
  assign seq_busy_o                 = (state_q != DPSW_IDLE);
  assign seq_index_o                = idx_q;
  assign dac_mute_o                 = regs_q[REG_DAC_MUTE][DAC_MUTE_BIT];
  assign speaker_drive_on_o         = regs_q[REG_SPK_CTRL][SPK_DRIVE_LSB +: 2];
  assign charge_pump_on_o           = regs_q[REG_CP][CP_BIT];
  assign midrail_reference_select_o = regs_q[REG_PWR][VMID_LSB +: 2];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [RUN_W-1:0] run_cyc_q;
  logic             short_q;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_cyc_q <= '0;
      short_q   <= 1'b0;
    end else if (state_q == DPSW_IDLE) begin
      run_cyc_q <= '0;
      short_q   <= (idx_d == IDX_SPK_SLEEP) || (idx_d == IDX_SPK_WAKE);
    end else if (run_cyc_q != '1) begin
      run_cyc_q <= run_cyc_q + 20'h00001;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_launch_pd;
    !seq_busy_o && reg_wr_i && reg_addr_i == REG_SEQ_CTRL && reg_wdata_i == CODE_POWER_DOWN
      |=> seq_busy_o && seq_index_o == IDX_POWER_DOWN;
  endproperty
  a_launch_pd: assert property (p_launch_pd) else $error("power down not started");

  property p_launch_sleep;
    !seq_busy_o && reg_wr_i && reg_addr_i == REG_SEQ_CTRL && reg_wdata_i == CODE_SPK_SLEEP
      |=> seq_busy_o && seq_index_o == IDX_SPK_SLEEP;
  endproperty
  a_launch_sleep: assert property (p_launch_sleep) else $error("sleep not started");

  property p_launch_wake;
    !seq_busy_o && reg_wr_i && reg_addr_i == REG_SEQ_CTRL && reg_wdata_i == CODE_SPK_WAKE
      |=> seq_busy_o && seq_index_o == IDX_SPK_WAKE;
  endproperty
  a_launch_wake: assert property (p_launch_wake) else $error("wake not started");

  property p_rmw_keep;
    seq_we |-> ((seq_wdata ^ seq_old) & ~seq_mask) == '0;
  endproperty
  a_rmw_keep: assert property (p_rmw_keep) else $error("bits outside field changed");

  property p_pd_mute;
    seq_we && idx_q == IDX_POWER_DOWN |=> dac_mute_o ##1 (state_q == DPSW_WAIT) [*8];
  endproperty
  a_pd_mute: assert property (p_pd_mute) else $error("dac mute or delay missing");

  property p_pd_end;
    seq_we && idx_q == IDX_PD_LAST
      |=> !seq_busy_o && midrail_reference_select_o == 2'b00 && !charge_pump_on_o;
  endproperty
  a_pd_end: assert property (p_pd_end) else $error("power down did not end");

  property p_sleep_off;
    seq_we && idx_q == IDX_SLEEP_LAST |=> !seq_busy_o && speaker_drive_on_o == 2'b00;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("speaker still driven");

  property p_wake_on;
    seq_we && idx_q == IDX_SPK_WAKE |=> speaker_drive_on_o == 2'b11 && seq_index_o == 7'h69;
  endproperty
  a_wake_on: assert property (p_wake_on) else $error("speaker not enabled");

  property p_short_time;
    short_q && seq_busy_o |-> run_cyc_q < RUN_W'(SEQ_LIMIT_CYC);
  endproperty
  a_short_time: assert property (p_short_time) else $error("sleep or wake too slow");

  property p_auto_sleep;
    !seq_busy_o && pend_sleep_q && !bus_launch |=> seq_busy_o && seq_index_o == IDX_SPK_SLEEP;
  endproperty
  a_auto_sleep: assert property (p_auto_sleep) else $error("auto sleep missed");

  property p_auto_wake;
    !seq_busy_o && pend_wake_q && !pend_sleep_q && !bus_launch
      |=> seq_busy_o && seq_index_o == IDX_SPK_WAKE;
  endproperty
  a_auto_wake: assert property (p_auto_wake) else $error("auto wake missed");

endmodule // dpsw_top

/* File: verification/dpsw_testbench.sv */
// self-checking bench for the default power sequence writer
// assumes dpsw_pkg and dpsw_top compiled first; short delay unit keeps runs brief
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import dpsw_pkg::*;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int unsigned LIM = 200;
  logic              sys_clk_i;
  logic              rst_b_i;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i;
  logic              reg_wr_i;
  logic              reg_rd_i;
  logic [DATA_W-1:0] reg_rdata_o;
  logic [DATA_W-1:0] dac_sample_i;
  logic              dac_sample_vld_i;
  logic              seq_busy_o;
  logic [IDX_W-1:0]  seq_index_o;
  logic              dac_mute_o;
  logic [1:0]        speaker_drive_on_o;
  logic              charge_pump_on_o;
  logic [1:0]        midrail_reference_select_o;
  int                n_fail;
  int                checked;
  int                n;
  logic [DATA_W-1:0] got;
  // preload words and the words left after power down
  logic [7:0]  pa [17] = '{8'h05, 8'h00, 8'h01, 8'h02, 8'h03, 8'h28, 8'h29, 8'h3c, 8'h3d,
                           8'h45, 8'h60, 8'h31, 8'h63, 8'h1a, 8'h48, 8'h19, 8'h1c};
  logic [15:0] pi [17] = '{16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'h007f, 16'hffff,
                           16'h007f, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
                           16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff};
  logic [15:0] pe [17] = '{16'h0008, 16'h0080, 16'h0180, 16'hff80, 16'h0100, 16'hff80,
                           16'h0100, 16'hff07, 16'hff07, 16'hff00, 16'hff00, 16'hff3f,
                           16'hfff0, 16'hfe07, 16'hfffe, 16'hfe01, 16'hffe7};

  dpsw_top #(.DELAY_UNIT_CYC(1), .SEQ_LIMIT_CYC(LIM)) u_dpsw_top (
    .sys_clk_i                  (sys_clk_i),
    .rst_b_i                    (rst_b_i),
    .reg_addr_i                 (reg_addr_i),
    .reg_wdata_i                (reg_wdata_i),
    .reg_wr_i                   (reg_wr_i),
    .reg_rd_i                   (reg_rd_i),
    .reg_rdata_o                (reg_rdata_o),
    .dac_sample_i               (dac_sample_i),
    .dac_sample_vld_i           (dac_sample_vld_i),
    .seq_busy_o                 (seq_busy_o),
    .seq_index_o                (seq_index_o),
    .dac_mute_o                 (dac_mute_o),
    .speaker_drive_on_o         (speaker_drive_on_o),
    .charge_pump_on_o           (charge_pump_on_o),
    .midrail_reference_select_o (midrail_reference_select_o)
  );

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  // bounded wait: busy must rise within 7 cycles and fall within 1000
  task automatic run_wait(output int cyc);
    int k;
    cyc = 0;
    k = 0;
    #1;
    while (seq_busy_o !== 1'b1 && k < 8) begin
      @(posedge sys_clk_i);
      #1;
      k++;
    end
    while (seq_busy_o === 1'b1 && cyc < 1000) begin
      @(posedge sys_clk_i);
      #1;
      cyc++;
    end
    if (seq_busy_o !== 1'b0 || k == 8) begin
      n_fail++;
      $display("BAD sequencer run expected finish seen timeout");
      complete_run();
    end
  endtask

  // ---------------------------------------------------------------
  // clock and sequence
  // ---------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    rst_b_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 16'h0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    dac_sample_i = 16'h0000;
    dac_sample_vld_i = 1'b0;
    n_fail = 0;
    checked = 0;
    repeat (20) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    rd(REG_SEQ_CTRL, got);
    chk("ctrl reset", 16'h0000, got);
    rd(REG_SEQ_CFG, got);
    chk("cfg reset", 16'h0000, got);
    // preload all ones where fields get cleared, except 16'h007f at 8'h03 and 8'h29 and no preload at 8'h3e, so a wide mask shows up
    for (int i = 0; i < 17; i++) wr(pa[i], pi[i]);
    wr(REG_SEQ_CTRL, CODE_POWER_DOWN);
    #1;
    chk("pd start index", 16'h001b, {9'h0, seq_index_o});
    repeat (100) @(posedge sys_clk_i);
    #1;
    chk("pd index in delay", 16'h001b, {9'h0, seq_index_o});
    chk("dac mute early", 16'h0001, {15'h0, dac_mute_o});
    chk("pump on in delay", 16'h0001, {15'h0, charge_pump_on_o});
    // a launch while busy is stored but starts nothing
    wr(REG_SEQ_CTRL, CODE_SPK_SLEEP);
    rd(REG_SEQ_STAT, got);
    chk("status in delay", 16'h009b, got);
    run_wait(n);
    rd(REG_SEQ_STAT, got);
    chk("status after pd", 16'h0031, got);
    for (int i = 0; i < 17; i++) begin
      rd(pa[i], got);
      chk("pd word", pe[i], got);
    end
    chk("pump off", 16'h0000, {15'h0, charge_pump_on_o});
    chk("midrail off", 16'h0000, {14'h0, midrail_reference_select_o});
    wr(REG_SPK_CTRL, 16'h0000);
    wr(REG_SEQ_CTRL, CODE_SPK_SLEEP);
    #1;
    chk("sleep start index", 16'h0064, {9'h0, seq_index_o});
    // a bus write in an entry's slot holds that entry one cycle
    wr(REG_SEQ_STAT, 16'h0000);
    #1;
    chk("entry held by bus write", 16'h0065, {9'h0, seq_index_o});
    run_wait(n);
    chk("sleep in time", 16'h0001, {15'h0, n <= LIM});
    rd(REG_SPK_CTRL, got);
    chk("sleep word", 16'h0017, got);
    rd(REG_SEQ_STAT, got);
    chk("status after sleep", 16'h0066, got);
    wr(REG_SEQ_CTRL, CODE_SPK_WAKE);
    #1;
    chk("wake start index", 16'h0068, {9'h0, seq_index_o});
    run_wait(n);
    chk("wake in time", 16'h0001, {15'h0, n <= LIM});
    rd(REG_SPK_CTRL, got);
    chk("wake word", 16'h00c4, got);
    chk("drive on", 16'h0003, {14'h0, speaker_drive_on_o});
    // automatic mode: quiet playback then a nonzero sample
    wr(REG_SEQ_CFG, 16'h0001);
    rd(REG_SEQ_CFG, got);
    chk("cfg auto on", 16'h0001, got);
    repeat (1024) begin
      @(posedge sys_clk_i);
      dac_sample_vld_i <= 1'b1;
      dac_sample_i     <= 16'h0000;
    end
    @(posedge sys_clk_i);
    dac_sample_vld_i <= 1'b0;
    run_wait(n);
    rd(REG_SPK_CTRL, got);
    chk("auto sleep word", 16'h0017, got);
    @(posedge sys_clk_i);
    dac_sample_vld_i <= 1'b1;
    dac_sample_i     <= 16'h0001;
    @(posedge sys_clk_i);
    dac_sample_vld_i <= 1'b0;
    run_wait(n);
    rd(REG_SPK_CTRL, got);
    chk("auto wake word", 16'h00c4, got);
    complete_run();
  end
endmodule // testbench
